/* core/ceesm_pkg.sv */
// package: constants and state types of the correctable error status and mask bank
//==========================================================
// Summary of operation
// - receiver error sets sticky write-one-clear status bit
// - bad packet sets its status bit
// - bad link packet sets its status bit
// - replay count rollover sets its status bit
// - replay timer expiry sets its status bit
// - advisory non-fatal error sets its status bit
// - reporting disabled: single-bit status and mask read zero
// - set mask bit suppresses reporting that event
// - masks reset zero, advisory mask resets one
// - single-bit masked only when mask and enable set
// - masked single-bit error is logged but not reported
// - masking never stops the status bit setting
package ceesm_pkg;
   //==========================================================
   // register map, byte addresses
   localparam int CE_ADDR_W = 12;
   localparam int CE_DATA_W = 32;
   localparam logic [11:0] CE_STATUS_OFS = 12'h110;
   localparam logic [11:0] CE_MASK_OFS = 12'h114;
   localparam logic [11:0] CE_MEMCTL_OFS = 12'h300;
   localparam logic [11:0] CE_IRQEN_OFS = 12'h304;
   //==========================================================
   // field positions of status and mask
   localparam int CE_RCV_BIT = 0;
   localparam int CE_BADPKT_BIT = 6;
   localparam int CE_BADLNK_BIT = 7;
   localparam int CE_ROLL_BIT = 8;
   localparam int CE_RTO_BIT = 12;
   localparam int CE_ADV_BIT = 13;
   localparam int CE_SBE_BIT = 31;
   localparam int CE_MEMCTL_SBE_BIT = 0;
   localparam logic [31:0] CE_DEFINED = 32'h800031C1;
   localparam logic [31:0] CE_SBE_MASK = 32'h80000000;
   localparam logic [31:0] CE_ZERO = 32'h00000000;
   //==========================================================
   // reset values
   localparam logic [31:0] CE_STATUS_RST = 32'h00000000;
   localparam logic [31:0] CE_MASK_RST = 32'h00002000;
   localparam logic CE_SBE_EN_RST = 1'b0;
   localparam logic [31:0] CE_IRQEN_RST = 32'h00000000;
   //==========================================================
   // state of the register bank
   typedef struct packed {
      logic [31:0] status;
      logic [31:0] mask;
      logic sbe_en;
      logic [31:0] irq_en;
   } ceesm_state_t;
endpackage : ceesm_pkg

/* core/ceesm_if.sv */
// interface: register access between the bus slave and the register bank
`timescale 1ns/10ps
interface ceesm_if;
   import ceesm_pkg::*;
   logic wr;
   logic [CE_ADDR_W-1:0] addr;
   logic [CE_DATA_W-1:0] wdata;
   logic [CE_DATA_W-1:0] rdata;
   logic hit;
   modport apb (output wr, output addr, output wdata, input rdata, input hit);
   modport regs (input wr, input addr, input wdata, output rdata, output hit);
endinterface : ceesm_if

/* core/ceesm_apb.sv */
// module: zero-wait APB slave front end of the register bank
`timescale 1ns/10ps
module ceesm_apb
   import ceesm_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [CE_ADDR_W-1:0] i_paddr,
   input wire logic [CE_DATA_W-1:0] i_pwdata,
   output logic [CE_DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   ceesm_if.apb bus
);
   typedef struct packed {
      logic [CE_DATA_W-1:0] prdata;
      logic pslverr;
   } ceesm_apb_t;
   ceesm_apb_t st_reg;
   ceesm_apb_t st_next;

   //==========================================================
   // request path: write acts only in the access phase
   assign bus.wr = i_psel && i_penable && i_pwrite;
   assign bus.addr = i_paddr;
   assign bus.wdata = i_pwdata;
   assign o_pready = 1'b1; // never stretches the access phase

   // answer captured in setup so read data comes from flops
   always_comb begin
      st_next = st_reg;
      if (i_psel && !i_penable) begin
         st_next.prdata = bus.hit ? bus.rdata : CE_ZERO;
         st_next.pslverr = !bus.hit;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_prdata = st_reg.prdata;
   assign o_pslverr = st_reg.pslverr;
endmodule : ceesm_apb

/* core/ceesm_report.sv */
// module: per-event report strobes and interrupt level of the bank
`timescale 1ns/10ps
module ceesm_report
   import ceesm_pkg::*;
#(
   parameter int W = 32
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_event,
   input wire logic [W-1:0] i_mask_eff,
   input wire logic [W-1:0] i_status,
   input wire logic [W-1:0] i_irq_en,
   output logic o_report,
   output logic [W-1:0] o_report_bits,
   output logic o_irq
);
   if (W != CE_DATA_W) begin : g_bad_width
      $error("report width must match the register width");
   end

   typedef struct packed {
      logic [W-1:0] bits;
      logic report;
      logic irq;
   } ceesm_rep_t;
   ceesm_rep_t st_reg;
   ceesm_rep_t st_next;
   logic [W-1:0] pass;

   //==========================================================
   // per bit: an event leaves only when its mask is clear
   for (genvar b = 0; b < W; b++) begin : g_bit
      assign pass[b] = i_event[b] && !i_mask_eff[b];
   end

   always_comb begin
      st_next.bits = pass;
      st_next.report = |pass;
      st_next.irq = |(i_status & i_irq_en);
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_report = st_reg.report;
   assign o_report_bits = st_reg.bits;
   assign o_irq = st_reg.irq;
endmodule : ceesm_report

/* core/ceesm_top.sv */
// module: correctable error status, mask and control register bank
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module ceesm_top
   import ceesm_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_hot_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [CE_ADDR_W-1:0] i_paddr,
   input wire logic [CE_DATA_W-1:0] i_pwdata,
   output logic [CE_DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_receiver_error,
   input wire logic i_bad_packet_error,
   input wire logic i_bad_link_packet_error,
   input wire logic i_replay_count_rollover,
   input wire logic i_replay_timeout,
   input wire logic i_advisory_nonfatal,
   input wire logic i_single_bit_error,
   output logic o_corr_report,
   output logic [CE_DATA_W-1:0] o_report_bits,
   output logic o_irq
);
   localparam ceesm_state_t ST_RST = '{
      status: CE_STATUS_RST,
      mask: CE_MASK_RST,
      sbe_en: CE_SBE_EN_RST,
      irq_en: CE_IRQEN_RST
   };

   ceesm_state_t st_reg;
   ceesm_state_t st_next;
   ceesm_if bus ();

   logic [31:0] ev_raw;
   logic [31:0] live;
   logic [31:0] ev_eff;
   logic [31:0] mask_eff;
   logic [31:0] clr;
   logic wr_status;
   logic wr_mask;
   logic wr_memctl;
   logic wr_irqen;

   //==========================================================
   // bus slave
   ceesm_apb u_apb (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_paddr(i_paddr),
      .i_pwdata(i_pwdata),
      .o_prdata(o_prdata),
      .o_pready(o_pready),
      .o_pslverr(o_pslverr),
      .bus(bus)
   );

   //==========================================================
   // event vector
   // detectors sit on this clock, so no synchroniser is needed
   function automatic logic [31:0] gather(
      input logic rcv,
      input logic pkt,
      input logic lnk,
      input logic roll,
      input logic rto,
      input logic adv,
      input logic single_bit_error
   );
      logic [31:0] v;
      v = CE_ZERO;
      v[CE_RCV_BIT] = rcv;
      v[CE_BADPKT_BIT] = pkt;
      v[CE_BADLNK_BIT] = lnk;
      v[CE_ROLL_BIT] = roll;
      v[CE_RTO_BIT] = rto;
      v[CE_ADV_BIT] = adv;
      v[CE_SBE_BIT] = single_bit_error;
      return v;
   endfunction : gather

   assign ev_raw = gather(i_receiver_error, i_bad_packet_error,
      i_bad_link_packet_error, i_replay_count_rollover,
      i_replay_timeout, i_advisory_nonfatal, i_single_bit_error);

   // bits that exist right now; single-bit error only when enabled
   assign live = st_reg.sbe_en ? CE_DEFINED : (CE_DEFINED & ~CE_SBE_MASK);
   assign ev_eff = ev_raw & live;
   // single-bit mask counts only while reporting is enabled
   assign mask_eff = st_reg.mask & live;

   //==========================================================
   // write decode
   assign wr_status = bus.wr && (bus.addr == CE_STATUS_OFS);
   assign wr_mask = bus.wr && (bus.addr == CE_MASK_OFS);
   assign wr_memctl = bus.wr && (bus.addr == CE_MEMCTL_OFS);
   assign wr_irqen = bus.wr && (bus.addr == CE_IRQEN_OFS);
   assign clr = wr_status ? (bus.wdata & live) : CE_ZERO;

   //==========================================================
   // next state of the bank
   always_comb begin
      st_next = st_reg;
      // set wins over a clear in the same cycle
      st_next.status = ((st_reg.status & ~clr) | ev_eff) & live;
      if (wr_mask) begin
         // stored single-bit mask survives while writes to it are ignored
         st_next.mask = (bus.wdata & live) | (st_reg.mask & CE_DEFINED & ~live);
      end
      if (wr_memctl) begin
         st_next.sbe_en = bus.wdata[CE_MEMCTL_SBE_BIT];
      end
      if (wr_irqen) begin
         st_next.irq_en = bus.wdata & CE_DEFINED;
      end
      // hot reset spares the mask and all sticky status except single-bit, dropped a cycle later as sbe_en resets
      if (i_hot_reset) begin
         st_next.sbe_en = CE_SBE_EN_RST;
         st_next.irq_en = CE_IRQEN_RST;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_reg <= ST_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   //==========================================================
   // read decode
   always_comb begin
      bus.rdata = CE_ZERO;
      bus.hit = 1'b1;
      if (bus.addr == CE_STATUS_OFS) begin
         bus.rdata = st_reg.status & live;
      end else if (bus.addr == CE_MASK_OFS) begin
         bus.rdata = st_reg.mask & live;
      end else if (bus.addr == CE_MEMCTL_OFS) begin
         bus.rdata[CE_MEMCTL_SBE_BIT] = st_reg.sbe_en;
      end else if (bus.addr == CE_IRQEN_OFS) begin
         bus.rdata = st_reg.irq_en;
      end else begin
         bus.hit = 1'b0;
      end
   end

   //==========================================================
   // reporting and interrupt
   ceesm_report #(
      .W(CE_DATA_W)
   ) u_report (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_event(ev_eff),
      .i_mask_eff(mask_eff),
      .i_status(st_reg.status),
      .i_irq_en(st_reg.irq_en),
      .o_report(o_corr_report),
      .o_report_bits(o_report_bits),
      .o_irq(o_irq)
   );

   //==========================================================
   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   // helper: high in the first cycle after reset release
   logic first_reg;
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         first_reg <= 1'b1;
      end else begin
         first_reg <= 1'b0;
      end
   end

   rcv_set_a: assert property (
      i_receiver_error |=> st_reg.status[CE_RCV_BIT]
      && (o_report_bits[CE_RCV_BIT] == !$past(st_reg.mask[CE_RCV_BIT]))
   ) else $error("receiver error not captured");

   rcv_clear_a: assert property (
      wr_status && bus.wdata[CE_RCV_BIT] && !i_receiver_error |=> !st_reg.status[CE_RCV_BIT]
   ) else $error("status bit not cleared by a one");

   hold_a: assert property (
      st_reg.status[CE_RTO_BIT] && !(wr_status && bus.wdata[CE_RTO_BIT])
      |=> st_reg.status[CE_RTO_BIT]
   ) else $error("status bit lost without a clear");

   badpkt_set_a: assert property (
      i_bad_packet_error |=> st_reg.status[CE_BADPKT_BIT]
   ) else $error("bad packet not captured");

   badlnk_set_a: assert property (
      i_bad_link_packet_error |=> st_reg.status[CE_BADLNK_BIT]
   ) else $error("bad link packet not captured");

   rollover_set_a: assert property (
      i_replay_count_rollover |=> st_reg.status[CE_ROLL_BIT]
   ) else $error("rollover not captured");

   timeout_set_a: assert property (
      i_replay_timeout |=> st_reg.status[CE_RTO_BIT]
   ) else $error("replay timeout not captured");

   advisory_set_a: assert property (
      i_advisory_nonfatal |=> st_reg.status[CE_ADV_BIT]
   ) else $error("advisory error not captured");

   sbe_set_a: assert property (
      st_reg.sbe_en && !i_hot_reset && !wr_memctl && i_single_bit_error
      |=> st_reg.status[CE_SBE_BIT]
   ) else $error("single-bit error not captured");

   sbe_off_a: assert property (
      !st_reg.sbe_en && (bus.addr == CE_STATUS_OFS || bus.addr == CE_MASK_OFS)
      |-> !bus.rdata[CE_SBE_BIT]
   ) else $error("single-bit field visible while disabled");

   mask_report_a: assert property (
      ev_eff[CE_BADLNK_BIT] && st_reg.mask[CE_BADLNK_BIT]
      |=> !o_report_bits[CE_BADLNK_BIT]
   ) else $error("masked event was reported");

   unmasked_report_a: assert property (
      ev_eff[CE_RCV_BIT] && !st_reg.mask[CE_RCV_BIT] |=> o_corr_report && o_report_bits[CE_RCV_BIT]
   ) else $error("unmasked event not reported");

   mask_reset_a: assert property (
      first_reg |-> st_reg.mask == CE_MASK_RST && st_reg.status == CE_STATUS_RST
   ) else $error("mask reset value wrong");

   sbe_mask_a: assert property (
      ev_eff[CE_SBE_BIT] && !st_reg.mask[CE_SBE_BIT] |=> o_report_bits[CE_SBE_BIT]
   ) else $error("single-bit error masked without its mask bit");

   sbe_silent_a: assert property (
      ev_eff[CE_SBE_BIT] && mask_eff[CE_SBE_BIT] |=> !o_report_bits[CE_SBE_BIT]
   ) else $error("masked single-bit error reported");

   sbe_status_a: assert property (
      i_single_bit_error && st_reg.sbe_en && st_reg.mask[CE_SBE_BIT] && !i_hot_reset && !wr_memctl
      |=> st_reg.status[CE_SBE_BIT]
   ) else $error("mask stopped single-bit status");

   reserved_a: assert property (
      (bus.addr == CE_STATUS_OFS || bus.addr == CE_MASK_OFS) |-> (bus.rdata & ~CE_DEFINED) == CE_ZERO
   ) else $error("reserved bits read nonzero");

   irq_level_a: assert property (
      |(st_reg.status & st_reg.irq_en) |=> o_irq
   ) else $error("interrupt not raised");

   //==========================================================
   // more checks: masking per event, reserved bits, sticky state
   // each masked event must stay out of the report vector
   rcv_mask_a: assert property (
      ev_eff[CE_RCV_BIT] && st_reg.mask[CE_RCV_BIT] |=> !o_report_bits[CE_RCV_BIT]
   ) else $error("masked receiver error reported");

   badpkt_mask_a: assert property (
      ev_eff[CE_BADPKT_BIT] && st_reg.mask[CE_BADPKT_BIT] |=> !o_report_bits[CE_BADPKT_BIT]
   ) else $error("masked bad packet reported");

   roll_mask_a: assert property (
      ev_eff[CE_ROLL_BIT] && st_reg.mask[CE_ROLL_BIT] |=> !o_report_bits[CE_ROLL_BIT]
   ) else $error("masked rollover reported");

   rto_mask_a: assert property (
      ev_eff[CE_RTO_BIT] && st_reg.mask[CE_RTO_BIT] |=> !o_report_bits[CE_RTO_BIT]
   ) else $error("masked replay timeout reported");

   adv_mask_a: assert property (
      ev_eff[CE_ADV_BIT] && st_reg.mask[CE_ADV_BIT] |=> !o_report_bits[CE_ADV_BIT]
   ) else $error("masked advisory error reported");

   adv_report_a: assert property (
      ev_eff[CE_ADV_BIT] && !st_reg.mask[CE_ADV_BIT] |=> o_report_bits[CE_ADV_BIT]
   ) else $error("unmasked advisory error not reported");

   badlnk_report_a: assert property (
      ev_eff[CE_BADLNK_BIT] && !st_reg.mask[CE_BADLNK_BIT] |=> o_report_bits[CE_BADLNK_BIT]
   ) else $error("unmasked bad link packet not reported");

   roll_report_a: assert property (
      ev_eff[CE_ROLL_BIT] && !st_reg.mask[CE_ROLL_BIT] |=> o_report_bits[CE_ROLL_BIT]
   ) else $error("unmasked rollover not reported");

   // reserved positions never hold state, so a read can never leak them
   status_rsvd_a: assert property (
      (st_reg.status & ~CE_DEFINED) == CE_ZERO
   ) else $error("reserved status bit set");

   mask_rsvd_a: assert property (
      (st_reg.mask & ~CE_DEFINED) == CE_ZERO
   ) else $error("reserved mask bit set");

   // disabling single-bit reporting drops its stored status a cycle later
   sbe_clear_a: assert property (
      !st_reg.sbe_en |=> !st_reg.status[CE_SBE_BIT]
   ) else $error("single-bit status kept while disabled");

   sbe_hold_a: assert property (
      wr_mask && !st_reg.sbe_en |=> st_reg.mask[CE_SBE_BIT] == $past(st_reg.mask[CE_SBE_BIT])
   ) else $error("single-bit mask written while disabled");

   // defined mask bits other than single-bit follow the written word
   mask_write_a: assert property (
      wr_mask |=> (st_reg.mask & ~CE_SBE_MASK) == ($past(bus.wdata) & CE_DEFINED & ~CE_SBE_MASK)
   ) else $error("mask write not stored");

   // with no event pending every written one clears its bit
   w1c_all_a: assert property (
      wr_status && ev_eff == CE_ZERO |=> (st_reg.status & $past(bus.wdata)) == CE_ZERO
   ) else $error("written one left a status bit set");

   // mask is sticky: only a mask write changes it, hot reset included
   mask_sticky_a: assert property (
      !wr_mask |=> st_reg.mask == $past(st_reg.mask)
   ) else $error("mask changed without a write");

   report_idle_a: assert property (
      ev_eff == CE_ZERO |=> !o_corr_report && o_report_bits == CE_ZERO
   ) else $error("report without an event");

   // interrupt follows the enabled status both ways
   irq_drop_a: assert property (
      (st_reg.status & st_reg.irq_en) == CE_ZERO |=> !o_irq
   ) else $error("interrupt held without a cause");

   first_quiet_a: assert property (
      first_reg |-> !o_corr_report && !o_irq && o_pready
   ) else $error("outputs active right after reset");
endmodule : ceesm_top

/* sim/ceesm_rc_model.sv */
// model: upstream root complex that counts the error reports it receives
`timescale 1ns/10ps
module ceesm_rc_model (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_report,
   input wire logic [31:0] i_report_bits,
   output logic [7:0] o_msg_count,
   output logic [31:0] o_bits_seen
);
   //==========================================================
   // report intake
   // each one-cycle pulse is one message; bits accumulate so a stray report shows
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_msg_count <= 8'h00;
         o_bits_seen <= 32'h00000000;
      end else if (i_report) begin
         o_msg_count <= o_msg_count + 8'h01;
         o_bits_seen <= o_bits_seen | i_report_bits;
      end
   end
endmodule : ceesm_rc_model

/* sim/correctable_error_status_mask_test.sv */
// testbench: correctable error status, mask and report checks over APB
`timescale 1ns/10ps
module correctable_error_status_mask_test;
   import ceesm_pkg::*;
   //==========================================================
   // stimulus and observed signals
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic hot = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [6:0] ev = 7'h00;
   logic [31:0] prdata, rbits, rd, seen_bits;
   logic pready, pslverr, serr, rep, irq;
   logic [7:0] msg_cnt;
   int err_total = 0;
   int tests_run = 0;
   int exp_rep = 0;
   int ev_pos [7] = '{0, 6, 7, 8, 12, 13, 31};
   always #10 clock = ~clock;
   //==========================================================
   // design and far side
   ceesm_top dut_u (.i_clock(clock), .i_rst_b(rst_b), .i_hot_reset(hot), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_receiver_error(ev[0]), .i_bad_packet_error(ev[1]), .i_bad_link_packet_error(ev[2]),
      .i_replay_count_rollover(ev[3]), .i_replay_timeout(ev[4]), .i_advisory_nonfatal(ev[5]),
      .i_single_bit_error(ev[6]), .o_corr_report(rep), .o_report_bits(rbits), .o_irq(irq));
   ceesm_rc_model rc_u (.i_clock(clock), .i_rst_b(rst_b), .i_report(rep), .i_report_bits(rbits),
      .o_msg_count(msg_cnt), .o_bits_seen(seen_bits));
   //==========================================================
   // shared tasks
   task check(input string name, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task finish_test;
      if (err_total == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   // one APB transfer, entered and left at a rising edge; bounded wait on pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle cycle, so a following call never reassigns psel in this time step
      @(posedge clock);
      if (n >= 20) begin
         err_total++;
         finish_test;
      end
   endtask : apb
   // one-cycle event pulse, then the report of the following cycle is judged
   task pulse(input logic [6:0] e, input logic [31:0] exp_bits);
      ev <= e;
      @(posedge clock);
      ev <= 7'h00;
      @(negedge clock);
      check("report_bits", rbits, exp_bits);
      check("corr_report", {31'h0, rep}, {31'h0, |exp_bits});
      if (|exp_bits) exp_rep++;
      @(posedge clock);
   endtask : pulse
   //==========================================================
   // scenarios
   task t_reset;
      apb(1'b0, CE_STATUS_OFS, 32'h0);
      check("status_rst", rd, 32'h00000000);
      apb(1'b0, CE_MASK_OFS, 32'h0);
      check("mask_rst", rd, 32'h00002000);
      apb(1'b0, 12'h118, 32'h0);
      check("unmapped_err", {31'h0, serr}, 32'h00000001);
      check("unmapped_data", rd, 32'h00000000);
   endtask : t_reset
   task t_events;
      logic [31:0] b;
      apb(1'b1, CE_MASK_OFS, 32'h00000000);
      for (int i = 0; i < 6; i++) begin
         b = 32'h00000001 << ev_pos[i];
         pulse(7'h01 << i, b);
         apb(1'b0, CE_STATUS_OFS, 32'h0);
         check("status_set", rd, b);
         apb(1'b1, CE_STATUS_OFS, b);
         apb(1'b0, CE_STATUS_OFS, 32'h0);
         check("status_w1c", rd, 32'h00000000);
      end
   endtask : t_events
   task t_mask;
      apb(1'b1, CE_MASK_OFS, 32'hFFFFFFFF);
      apb(1'b0, CE_MASK_OFS, 32'h0);
      check("mask_rw", rd, 32'h000031C1);
      pulse(7'h3F, 32'h00000000);
      apb(1'b0, CE_STATUS_OFS, 32'h0);
      check("masked_status", rd, 32'h000031C1);
      apb(1'b1, CE_STATUS_OFS, 32'hFFFFFFFF);
      apb(1'b0, CE_STATUS_OFS, 32'h0);
      check("status_clear", rd, 32'h00000000);
   endtask : t_mask
   task t_sbe;
      apb(1'b1, CE_MASK_OFS, 32'h00000000);
      pulse(7'h40, 32'h00000000);
      apb(1'b0, CE_STATUS_OFS, 32'h0);
      check("sbe_off", rd, 32'h00000000);
      apb(1'b1, CE_MEMCTL_OFS, 32'h00000001);
      pulse(7'h40, 32'h80000000);
      apb(1'b0, CE_STATUS_OFS, 32'h0);
      check("sbe_on", rd, 32'h80000000);
      apb(1'b1, CE_MASK_OFS, 32'h80000000);
      apb(1'b1, CE_STATUS_OFS, 32'h80000000);
      pulse(7'h40, 32'h00000000);
      apb(1'b0, CE_STATUS_OFS, 32'h0);
      check("sbe_masked", rd, 32'h80000000);
      apb(1'b1, CE_MEMCTL_OFS, 32'h00000000);
      apb(1'b0, CE_STATUS_OFS, 32'h0);
      check("sbe_stat_off", rd, 32'h00000000);
      apb(1'b0, CE_MASK_OFS, 32'h0);
      check("sbe_mask_off", rd, 32'h00000000);
   endtask : t_sbe
   // irq rises with an enabled status bit; hot reset drops the enable, not the sticky bit
   task t_irq;
      apb(1'b1, CE_IRQEN_OFS, 32'h00000001);
      pulse(7'h01, 32'h00000001);
      @(negedge clock);
      check("irq_set", {31'h0, irq}, 32'h00000001);
      @(posedge clock);
      hot <= 1'b1;
      @(posedge clock);
      hot <= 1'b0;
      repeat (2) @(posedge clock);
      apb(1'b0, CE_STATUS_OFS, 32'h0);
      check("status_sticky", rd, 32'h00000001);
      check("irq_hot", {31'h0, irq}, 32'h00000000);
      apb(1'b1, CE_IRQEN_OFS, 32'h00000001);
      apb(1'b1, CE_STATUS_OFS, 32'h00000001);
      apb(1'b0, CE_STATUS_OFS, 32'h0);
      check("irq_clear", {31'h0, irq}, 32'h00000000);
   endtask : t_irq
   //==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      t_reset;
      t_events;
      t_mask;
      t_sbe;
      t_irq;
      check("report_count", {24'h0, msg_cnt}, exp_rep[31:0]);
      check("report_bits_all", seen_bits, 32'h800031C1);
      finish_test;
   end
endmodule : correctable_error_status_mask_test
